// [bench/osdw_sync_src.sv]
// Purpose: sync pin source standing in for the video path
// Assumes: bench requests pulses on sys_clk
// Notes: pins idle low; pulses are six clocks wide
`timescale 1ns/100ps
module osdw_sync_src (
  input wire logic sys_clk, // pixel clock
  input wire logic reset, // synchronous, active high
  input wire logic h_go, // request a line pulse
  input wire logic v_go, // request a field pulse
  output logic hsync_pin, // line sync pin
  output logic vsync_pin // field sync pin
);
  logic [2:0] h_q;
  logic [2:0] v_q;
  // wide enough to survive the three-stage pin filter
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      h_q <= 3'h0;
      v_q <= 3'h0;
    end else begin
      h_q <= h_go ? 3'h6 : (h_q != 3'h0 ? h_q - 3'h1 : 3'h0);
      v_q <= v_go ? 3'h6 : (v_q != 3'h0 ? v_q - 3'h1 : 3'h0);
    end
  end
  assign hsync_pin = (h_q != 3'h0);
  assign vsync_pin = (v_q != 3'h0);
endmodule

// [bench/osdw_top_tb.sv]
// Purpose: self-checking bench for the osd window block
// Assumes: zero-wait slave, hready tied to hreadyout
// Notes: samples taken after an edge see pre-edge register values
`timescale 1ns/100ps
module osdw_top_tb;
  import osdw_pkg::*;
  logic sys_clk, reset, hsel, hwrite, hreadyout, hresp, char_start;
  logic h_go, v_go, hsync_pin, vsync_pin;
  logic [9:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  osdw_char_t char_in;
  osdw_video_t video, vb, vo, vi;
  int error_cnt, num_checks, cyc, cnt, n0;
  logic [7:0] idx[4] = '{OSDW_IDX_HBLANK, OSDW_IDX_HSTART, OSDW_IDX_VSTART, OSDW_IDX_FSCC};
  logic [7:0] rv[4] = '{8'h03, 8'h03, 8'h00, 8'h00};
  // per mode: outside {shown, may be translucent}, inside the same
  logic [3:0] tab[8] = '{4'hf, 4'h0, 4'hf, 4'h0, 4'h3, 4'h3, 4'h8, 4'hc};

  osdw_top osdw_top_i (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .hsync_pin(hsync_pin),
    .vsync_pin(vsync_pin), .char_in(char_in), .video(video), .char_start(char_start));
  osdw_sync_src osdw_sync_src_i (.sys_clk(sys_clk), .reset(reset), .h_go(h_go),
    .v_go(v_go), .hsync_pin(hsync_pin), .vsync_pin(vsync_pin));

  // ---------------------------------------------------------------
  // bus, compare and line tasks
  // ---------------------------------------------------------------
  task automatic bus(input logic [7:0] i, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {i, 2'b00};
    hwrite <= w;
    htrans <= OSDW_HTRANS_NONSEQ;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pulse(input logic v);
    if (v) v_go <= 1'b1;
    else h_go <= 1'b1;
    @(posedge sys_clk);
    v_go <= 1'b0;
    h_go <= 1'b0;
  endtask

  // one line: blank sample, delay sample, then inside the text area
  task automatic frame(input logic [7:0] f, input logic t, input logic rs);
    bus(OSDW_IDX_FSCC, 1'b1, {24'h0, f});
    bus(OSDW_IDX_CTRL, 1'b1, {31'h0, t});
    pulse(1'b0);
    if (rs) begin
      repeat (10) @(posedge sys_clk);
      pulse(1'b0);
    end
    repeat (11) @(posedge sys_clk);
    vb = video;
    repeat (28) @(posedge sys_clk);
    vo = video;
    cnt = 0;
    while (char_start !== 1'b1 && cnt < 600) begin
      @(posedge sys_clk);
      cnt++;
    end
    repeat (3) @(posedge sys_clk);
    vi = video;
  endtask

  function automatic logic [5:0] col(input logic [3:0] c);
    logic [1:0] lv;
    lv = (c == OSDW_CODE_GREY) ? OSDW_LVL_GREY : (c[3] ? OSDW_LVL_DARK : OSDW_LVL_FULL);
    return {c[2] ? lv : 2'h0, c[1] ? lv : 2'h0, c[0] ? lv : 2'h0};
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // a hung wait still ends in the verdict
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    reset = 1'b1;
    {hsel, hwrite, h_go, v_go, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    char_in = '0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (int j = 0; j < 4; j++) begin
      bus(idx[j], 1'b0, 32'h0);
      cmp("reset value", {24'h0, rv[j]}, rd);
    end
    bus(8'h00, 1'b0, 32'h0);
    cmp("unmapped read", 32'h0, rd);
    bus(OSDW_IDX_VSTART, 1'b1, 32'h3f);
    bus(OSDW_IDX_VSTART, 1'b0, 32'h0);
    cmp("vstart readback", 32'h3f, rd);
    $display("test registers done");
    bus(OSDW_IDX_VSTART, 1'b1, 32'h03);
    pulse(1'b1);
    for (int k = 0; k < 4; k++) begin
      if (k > 0) pulse(1'b0);
      repeat (30) @(posedge sys_clk);
      bus(OSDW_IDX_STAT, 1'b0, 32'h0);
      if (k != 1) cmp("row delay", (k == 3) ? 7'h40 : 7'h03 - k, {rd[10], rd[5:0]});
    end
    $display("test vertical done");
    bus(OSDW_IDX_HBLANK, 1'b1, 32'd16);
    bus(OSDW_IDX_HSTART, 1'b1, 32'd40);
    frame(8'h07, 1'b0, 1'b0);
    n0 = cnt;
    frame(8'h07, 1'b0, 1'b1);
    cmp("restart", n0, cnt);
    bus(OSDW_IDX_HBLANK, 1'b1, 32'd23);
    frame(8'h07, 1'b0, 1'b0);
    cmp("blank length", n0 + 7, cnt);
    bus(OSDW_IDX_HBLANK, 1'b1, 32'd16);
    bus(OSDW_IDX_HSTART, 1'b1, 32'd46);
    frame(8'h07, 1'b0, 1'b0);
    cmp("start delay", n0 + 6, cnt);
    bus(OSDW_IDX_HSTART, 1'b1, 32'd40);
    $display("test timing done");
    for (int c = 0; c < 16; c++) begin
      frame({4'h0, 4'(c)}, 1'b0, 1'b0);
      cmp("blank black", 32'h0, {vb.fast_blank, vb.red, vb.green, vb.blue});
      cmp("colour", {1'b1, col(4'(c))}, {vo.fast_blank, vo.red, vo.green, vo.blue});
    end
    $display("test colours done");
    char_in <= {1'b0, 4'h0, 1'b1, 2'b00};
    for (int m = 0; m < 8; m++) begin
      for (int t = 0; t < 2; t++) begin
        frame({3'(m), 5'h01}, 1'(t), 1'b0);
        cmp("outside", {tab[m][3], tab[m][2] & 1'(t)}, {vo.fast_blank, vo.transl});
        cmp("inside", {tab[m][1], tab[m][0] & 1'(t)}, {vi.fast_blank, vi.transl});
      end
    end
    $display("test modes done");
    for (int h = 0; h < 2; h++) begin
      frame({3'h0, 1'(h), 4'h1}, 1'b1, 1'b0);
      cmp("shared pin", {31'h0, ~1'(h)}, vo.shared_pin);
      char_in <= {1'b1, 4'h7, 1'b1, 1'(h), 1'b1};
      frame(8'he7, 1'b0, 1'b0);
      cmp("flash header", {31'h0, ~1'(h)}, vi.fast_blank);
      char_in <= '0;
    end
    $display("test pin and header done");
    summarize();
  end
endmodule

// [core/osdw_pkg.sv]
// Purpose: shared constants and types of the osd window and background block
// Assumes: one clock, sys_clk at 250 MHz, doubling as the pixel clock
// Notes: register byte address is four times the register index
package osdw_pkg;
  // ---------------------------------------------------------------
  // register indices and bus geometry
  // ---------------------------------------------------------------
  localparam int OSDW_ADDR_W = 10;
  localparam logic [7:0] OSDW_IDX_HBLANK = 8'hf0;
  localparam logic [7:0] OSDW_IDX_HSTART = 8'hf1;
  localparam logic [7:0] OSDW_IDX_VSTART = 8'hf2;
  localparam logic [7:0] OSDW_IDX_FSCC = 8'hf3;
  localparam logic [7:0] OSDW_IDX_CTRL = 8'h10;
  localparam logic [7:0] OSDW_IDX_STAT = 8'h11;
  localparam logic [1:0] OSDW_HTRANS_NONSEQ = 2'h2;
  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] OSDW_RST_HBLANK = 8'h03;
  localparam logic [7:0] OSDW_RST_HSTART = 8'h03;
  localparam logic [5:0] OSDW_RST_VSTART = 6'h00;
  localparam logic [7:0] OSDW_RST_FSCC = 8'h00;
  localparam logic OSDW_RST_TRANSL = 1'b0;
  localparam int OSDW_FSCC_BE = 7;
  localparam int OSDW_FSCC_TIO = 6;
  localparam int OSDW_FSCC_MM = 5;
  localparam int OSDW_FSCC_HTC = 4;
  localparam int OSDW_CTRL_TRANSL = 0;
  // ---------------------------------------------------------------
  // timing: one pixel per clock, line period for the sync watchdog
  // ---------------------------------------------------------------
  localparam int OSDW_CLK_NS = 4;
  localparam int OSDW_TPIX_NS = 4;
  localparam int OSDW_TLINE_US = 64;
  localparam int OSDW_LINE_CYCLES = OSDW_TLINE_US * 1000 / OSDW_CLK_NS;
  localparam int OSDW_WD_W = 14;
  // ---------------------------------------------------------------
  // colour levels per channel
  // ---------------------------------------------------------------
  localparam logic [1:0] OSDW_LVL_FULL = 2'h3;
  localparam logic [1:0] OSDW_LVL_DARK = 2'h1;
  localparam logic [1:0] OSDW_LVL_GREY = 2'h2;
  localparam logic [3:0] OSDW_CODE_GREY = 4'hf;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {OSDW_H_BLANK, OSDW_H_DELAY, OSDW_H_ACTIVE} osdw_hphase_t;
  typedef enum logic [1:0] {OSDW_BG_SOLID, OSDW_BG_TRANSL, OSDW_BG_TRANSP, OSDW_BG_BLANK} osdw_bg_t;
  typedef struct packed {
    osdw_bg_t bg;
    logic text;
  } osdw_bgres_t;
  typedef struct packed {
    logic pixel;
    logic [3:0] colour;
    logic boxed;
    logic flash;
    logic header;
  } osdw_char_t;
  typedef struct packed {
    logic [1:0] red;
    logic [1:0] green;
    logic [1:0] blue;
    logic fast_blank;
    logic transl;
    logic halftone;
    logic shared_pin;
  } osdw_video_t;
  typedef struct packed {
    logic [7:0] hblank_len;
    logic [7:0] hstart;
    logic [5:0] vstart;
    logic [7:0] fscc;
    logic transl_en;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_idx;
    logic [31:0] rdata;
    logic readyout;
    logic hs_prev;
    logic vs_prev;
    osdw_hphase_t phase;
    logic [7:0] hb_cnt;
    logic [7:0] hp_cnt;
    logic [5:0] line_cnt;
    logic v_active;
    logic [OSDW_WD_W-1:0] wd_cnt;
    logic sync_lost;
    logic char_start;
    osdw_video_t vid;
    logic [7:0] chk_run;
    logic [7:0] chk_len;
  } osdw_state_t;
endpackage

// [core/osdw_sync3.sv]
// Purpose: three-stage synchroniser for a pin level
// Assumes: input is asynchronous to sys_clk
// Notes: level changes only once stages two and three agree
`timescale 1ns/100ps
module osdw_sync3 (
  input wire logic sys_clk, // pixel clock
  input wire logic reset, // synchronous, active high
  input wire logic pin, // raw pin level
  output logic level // filtered level
);
  import osdw_pkg::*;

  logic [3:0] s_q;
  logic [3:0] s_d;

  // ---------------------------------------------------------------
  // stage one feeds stage two only; the filter looks at two and three
  // ---------------------------------------------------------------
  always_comb begin
    s_d = {s_q[2:0], pin};
    s_d[3] = (s_q[1] == s_q[2]) ? s_q[2] : s_q[3];
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= 4'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q[3];
endmodule

// [core/osdw_top.sv]
// Purpose: osd window placement and background composition
// Assumes: sys_clk is the pixel clock; syncs are active high pins
// Notes: video outputs lag the character inputs by one clock
// Notes on behaviour
// - each hsync reloads blank counter from blank length
// - during blank, fast blanking low, colour black
// - start delay counted after blank, first character at zero
// - vsync loads line counter, hsync decrements it
// - select bit routes translucency or half-tone out
// - background colour is half-intensity, red, green, blue
// - codes map to colours, dark set, grey
// - no box, no mixed: solid or translucent
// - no box, mixed: transparent everywhere
// - box only: boxed text solid or translucent, rest blanked
// - box, mixed: boxed solid or translucent, rest transparent
// - all three: boxed transparent, rest solid or translucent
// - flashing boxed header under all three: transparent
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
module osdw_top #(
  parameter int unsigned LINE_CYCLES = osdw_pkg::OSDW_LINE_CYCLES // sync watchdog span
) (
  input wire logic sys_clk, // pixel clock
  input wire logic reset, // synchronous, active high
  input wire logic hsel, // slave select
  input wire logic [osdw_pkg::OSDW_ADDR_W-1:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic hsync_pin, // horizontal sync pin
  input wire logic vsync_pin, // vertical sync pin
  input wire osdw_pkg::osdw_char_t char_in, // character generator pixel
  output osdw_pkg::osdw_video_t video, // colour and blanking outputs
  output logic char_start // pulse: first character begins
);
  import osdw_pkg::*;

  osdw_state_t s_q;
  osdw_state_t s_d;
  logic hs_lvl;
  logic vs_lvl;
  logic hs_edge;
  logic vs_edge;
  logic in_text;
  logic text_px;
  logic [3:0] code;
  logic [5:0] rgb;
  osdw_bgres_t res;

  // ---------------------------------------------------------------
  // sync pins
  // ---------------------------------------------------------------
  osdw_sync3 u_hs (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin(hsync_pin),
    .level(hs_lvl)
  );

  osdw_sync3 u_vs (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin(vsync_pin),
    .level(vs_lvl)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // colour code to two-bit levels, red first
  function automatic logic [5:0] colour_rgb(input logic [3:0] c);
    logic [1:0] lvl;
    lvl = c[3] ? OSDW_LVL_DARK : OSDW_LVL_FULL;
    if (c == OSDW_CODE_GREY) begin
      colour_rgb = {3{OSDW_LVL_GREY}};
    end else begin
      colour_rgb = {c[2] ? lvl : 2'h0, c[1] ? lvl : 2'h0, c[0] ? lvl : 2'h0};
    end
  endfunction

  // background kind and text visibility from the box settings
  function automatic osdw_bgres_t bg_decode(input logic [7:0] f, input logic tl,
                                            input logic bx, input logic fl,
                                            input logic hd);
    osdw_bg_t sol;
    sol = tl ? OSDW_BG_TRANSL : OSDW_BG_SOLID;
    bg_decode.text = 1'b1;
    bg_decode.bg = sol;
    unique case ({f[OSDW_FSCC_BE], f[OSDW_FSCC_TIO], f[OSDW_FSCC_MM]})
      3'b000, 3'b010: bg_decode.bg = sol;
      3'b001, 3'b011: bg_decode.bg = OSDW_BG_TRANSP;
      3'b100: begin
        bg_decode.bg = bx ? sol : OSDW_BG_BLANK;
        bg_decode.text = bx;
      end
      3'b101: bg_decode.bg = bx ? sol : OSDW_BG_TRANSP;
      3'b110: begin
        bg_decode.bg = bx ? OSDW_BG_TRANSP : OSDW_BG_SOLID;
        bg_decode.text = !bx;
      end
      3'b111: begin
        bg_decode.bg = bx ? OSDW_BG_TRANSP : sol;
        bg_decode.text = !(bx && fl && hd);
      end
    endcase
  endfunction

  // register read view; reserved bits read zero
  function automatic logic [31:0] rd_word(input osdw_state_t s, input logic [7:0] idx);
    rd_word = 32'h0;
    unique case (idx)
      OSDW_IDX_HBLANK: rd_word[7:0] = s.hblank_len;
      OSDW_IDX_HSTART: rd_word[7:0] = s.hstart;
      OSDW_IDX_VSTART: rd_word[5:0] = s.vstart; // upper bits held zero
      OSDW_IDX_FSCC: rd_word[7:0] = s.fscc;
      OSDW_IDX_CTRL: rd_word[OSDW_CTRL_TRANSL] = s.transl_en;
      OSDW_IDX_STAT: rd_word[11:0] = {s.sync_lost, s.v_active, s.phase, 2'h0, s.line_cnt};
      default: rd_word = 32'h0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    hs_edge = hs_lvl && !s_q.hs_prev;
    vs_edge = vs_lvl && !s_q.vs_prev;
    s_d.hs_prev = hs_lvl;
    s_d.vs_prev = vs_lvl;
    s_d.char_start = 1'b0;

    // bus data phase: write lands before any read in the same cycle
    if (s_q.dp_valid && s_q.dp_write) begin
      unique case (s_q.dp_idx)
        OSDW_IDX_HBLANK: s_d.hblank_len = hwdata[7:0];
        OSDW_IDX_HSTART: s_d.hstart = hwdata[7:0];
        OSDW_IDX_VSTART: s_d.vstart = hwdata[5:0];
        OSDW_IDX_FSCC: s_d.fscc = hwdata[7:0];
        OSDW_IDX_CTRL: s_d.transl_en = hwdata[OSDW_CTRL_TRANSL];
        default: s_d.transl_en = s_d.transl_en;
      endcase
    end
    // bus address phase: zero wait, read word prepared for the data phase
    s_d.dp_valid = hsel && hready && htrans == OSDW_HTRANS_NONSEQ;
    s_d.dp_write = hwrite;
    s_d.dp_idx = haddr[OSDW_ADDR_W-1:2];
    s_d.rdata = s_d.dp_valid && !hwrite ? rd_word(s_d, haddr[OSDW_ADDR_W-1:2]) : 32'h0;
    s_d.readyout = 1'b1;

    // horizontal sequencer, one step per pixel clock
    unique case (s_q.phase)
      OSDW_H_BLANK: begin
        s_d.hb_cnt = s_q.hb_cnt - 8'h01;
        if (s_q.hb_cnt <= 8'h01) begin
          s_d.phase = OSDW_H_DELAY;
        end
      end
      OSDW_H_DELAY: begin
        if (s_q.hp_cnt == 8'h00) begin
          s_d.phase = OSDW_H_ACTIVE;
          s_d.char_start = 1'b1;
        end else begin
          s_d.hp_cnt = s_q.hp_cnt - 8'h01;
        end
      end
      OSDW_H_ACTIVE: s_d.phase = OSDW_H_ACTIVE;
    endcase

    // sync restarts the line; a zero blank length skips the blank
    if (hs_edge) begin
      s_d.hb_cnt = s_q.hblank_len;
      s_d.hp_cnt = s_q.hstart;
      s_d.phase = s_q.hblank_len == 8'h00 ? OSDW_H_DELAY : OSDW_H_BLANK;
      if (s_q.line_cnt != 6'h00) begin
        s_d.line_cnt = s_q.line_cnt - 6'h01;
        s_d.v_active = s_q.line_cnt == 6'h01;
      end
    end
    // vsync wins over a coinciding hsync for the line counter
    if (vs_edge) begin
      s_d.line_cnt = s_q.vstart;
      s_d.v_active = s_q.vstart == 6'h00;
    end

    // watchdog: no hsync for a whole line period flags loss
    if (hs_edge) begin
      s_d.wd_cnt = '0;
      s_d.sync_lost = 1'b0;
    end else if (s_q.wd_cnt >= OSDW_WD_W'(LINE_CYCLES)) begin
      s_d.sync_lost = 1'b1;
    end else begin
      s_d.wd_cnt = s_q.wd_cnt + OSDW_WD_W'(1);
    end

    // background composition; outside the text area nothing is boxed
    in_text = s_q.v_active && s_q.phase == OSDW_H_ACTIVE;
    res = bg_decode(s_q.fscc, s_q.transl_en, in_text && char_in.boxed,
                    char_in.flash, in_text && char_in.header);
    text_px = in_text && res.text && char_in.pixel;
    code = text_px ? char_in.colour : s_q.fscc[3:0];
    rgb = colour_rgb(code);
    if (!text_px && (res.bg == OSDW_BG_TRANSP || res.bg == OSDW_BG_BLANK)) begin
      rgb = 6'h00;
    end
    s_d.vid.fast_blank = text_px || res.bg == OSDW_BG_SOLID || res.bg == OSDW_BG_TRANSL;
    s_d.vid.transl = !text_px && res.bg == OSDW_BG_TRANSL;
    s_d.vid.halftone = s_d.vid.fast_blank && code[3];
    if (s_q.phase == OSDW_H_BLANK) begin
      rgb = 6'h00;
      s_d.vid.fast_blank = 1'b0;
      s_d.vid.transl = 1'b0;
      s_d.vid.halftone = 1'b0;
    end
    {s_d.vid.red, s_d.vid.green, s_d.vid.blue} = rgb;
    s_d.vid.shared_pin = s_q.fscc[OSDW_FSCC_HTC] ? s_d.vid.halftone : s_d.vid.transl;

    // check helpers: run length of each blank and the length it loaded
    s_d.chk_run = s_q.phase == OSDW_H_BLANK ? s_q.chk_run + 8'h01 : 8'h00;
    if (hs_edge) begin
      s_d.chk_run = 8'h00;
      s_d.chk_len = s_q.hblank_len;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.hblank_len <= OSDW_RST_HBLANK;
      s_q.hstart <= OSDW_RST_HSTART;
      s_q.vstart <= OSDW_RST_VSTART;
      s_q.fscc <= OSDW_RST_FSCC;
      s_q.transl_en <= OSDW_RST_TRANSL;
      s_q.readyout <= 1'b1;
      s_q.phase <= OSDW_H_DELAY;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register; hresp tied low
  assign hreadyout = s_q.readyout;
  assign hrdata = s_q.rdata;
  assign hresp = 1'b0;
  assign video = s_q.vid;
  assign char_start = s_q.char_start;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  blank_len_a: assert property (
    s_q.phase == OSDW_H_BLANK ##1 s_q.phase == OSDW_H_DELAY && !$past(hs_edge)
    |-> s_q.chk_run == s_q.chk_len)
    else $error("blank length differs from loaded value");

  blank_black_a: assert property (
    s_q.phase == OSDW_H_BLANK |=> !video.fast_blank && video.red == 2'h0
    && video.green == 2'h0 && video.blue == 2'h0)
    else $error("output not black during blank");

  first_char_a: assert property (
    s_q.phase == OSDW_H_DELAY && s_q.hp_cnt == 8'h00 && !hs_edge
    |=> char_start && s_q.phase == OSDW_H_ACTIVE ##1 !char_start)
    else $error("first character start misplaced");

  line_load_a: assert property (
    vs_edge |=> s_q.line_cnt == $past(s_q.vstart)
    && s_q.v_active == ($past(s_q.vstart) == 6'h00))
    else $error("line counter not loaded on vsync");

  pin_route_a: assert property (
    s_q.fscc[OSDW_FSCC_HTC] |=> video.shared_pin == video.halftone
    || $changed(s_q.fscc))
    else $error("shared pin not following select");

  mixed_transp_a: assert property (
    !s_q.fscc[OSDW_FSCC_BE] && s_q.fscc[OSDW_FSCC_MM] && !char_in.pixel
    |=> !video.fast_blank)
    else $error("mixed mode background not transparent");

  box_outside_a: assert property (
    s_q.fscc[7:5] == 3'b100 && in_text && !char_in.boxed |=> !video.fast_blank)
    else $error("text outside box not blanked");

  box_hide_a: assert property (
    s_q.fscc[7:5] == 3'b110 && in_text && char_in.boxed |=> !video.fast_blank)
    else $error("boxed text shown in text-out mode");

  flash_header_a: assert property (
    s_q.fscc[7:5] == 3'b111 && in_text && char_in.boxed && char_in.flash
    && char_in.header |=> !video.fast_blank && !video.transl)
    else $error("flashing boxed header not transparent");

  solid_fill_a: assert property (
    s_q.fscc[7:5] == 3'b000 && s_q.transl_en && s_q.phase != OSDW_H_BLANK
    && !text_px |=> video.transl && video.fast_blank)
    else $error("translucent fill missing");

  bus_ready_a: assert property (
    s_q.dp_valid |-> hreadyout && !hresp)
    else $error("slave stalled or erred");

  blank_seen_c: cover property (s_q.phase == OSDW_H_BLANK ##1 s_q.phase == OSDW_H_DELAY);
  start_seen_c: cover property (char_start);
  rows_on_c: cover property ($rose(s_q.v_active));
  transl_on_c: cover property (video.transl);
endmodule
